// ==== design/pgpc_pad_cell.sv ====
/*
 pgpc_pad_cell: per-pin output drive, open-drain and pull control.
 Assumes the control set comes from flops on mclk_i; registered outputs.
*/
module pgpc_pad_cell #(
    parameter pgpc_pkg::pgpc_pintype_e PTYPE = pgpc_pkg::PGPC_GENERAL_IO
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    // control of this pin
    input  wire logic drive_en_i,   // pin works as output
    input  wire logic drive_val_i,  // level to drive
    input  wire logic od_i,         // open-drain select
    input  wire logic pu_i,         // pull-up enable
    input  wire logic pd_i,         // pull-down enable
    // pad side
    output logic      out_o,
    output logic      oe_o,
    output logic      pu_o,
    output logic      pd_o
);
    // ==========================================================
    // drive: open-drain only drives low, oe high while driving
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_o <= 1'b0;
            oe_o  <= 1'b0;
        end else begin
            out_o <= drive_val_i;
            oe_o  <= drive_en_i && !(od_i && drive_val_i);
        end
    end
    // ==========================================================
    // pulls: forced during reset, async so no clock is needed
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pu_o <= (PTYPE == pgpc_pkg::PGPC_BOOT_IN); // R9
            pd_o <= 1'b0;                              // R8
        end else begin
            pu_o <= pu_i;
            pd_o <= pd_i;
        end
    end
endmodule // pgpc_pad_cell

// ==== design/pgpc_pkg.sv ====
/*
 pgpc_pkg: constants and carrier types of the eight-bit port pin control.
 Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package pgpc_pkg;
    // ==========================================================
    // geometry
    localparam int unsigned PINS = 8;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_LINE = 8'h00; // line value
    localparam logic [7:0] OFS_DIR  = 8'h04; // direction
    localparam logic [7:0] OFS_ALT  = 8'h08; // function select one
    localparam logic [7:0] OFS_OD   = 8'h0C; // open-drain select
    localparam logic [7:0] OFS_PU   = 8'h10; // pull-up enable
    localparam logic [7:0] OFS_PD   = 8'h14; // pull-down enable
    localparam logic [7:0] OFS_IE   = 8'h18; // input buffer enable
    localparam logic [7:0] OFS_PIN  = 8'h1C; // synchronised pin level
    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00; // every control bit
    // ==========================================================
    // alternate-function pin positions
    localparam int unsigned PIN_SCK = 0; // serial clock
    localparam int unsigned PIN_RXD = 1; // serial receive
    localparam int unsigned PIN_TXD = 2; // serial transmit
    localparam int unsigned PIN_CAP = 3; // timer one capture
    localparam int unsigned PIN_T1  = 4; // timer one flop out
    localparam int unsigned PIN_T4  = 5;
    localparam int unsigned PIN_T5  = 6;
    localparam int unsigned PIN_T6  = 7;
    // ==========================================================
    // pad type of a pin, chooses the pull behaviour in reset
    typedef enum logic [1:0] {
        PGPC_GENERAL_IO, PGPC_INTERRUPT_IN, PGPC_ANALOG_IN, PGPC_BOOT_IN
    } pgpc_pintype_e;
    // per-pin control set
    typedef struct packed {
        logic [7:0] port_line_value;
        logic [7:0] port_direction;
        logic [7:0] alt_function_select_one;
        logic [7:0] open_drain_select;
        logic [7:0] pull_up_enable;
        logic [7:0] pull_down_enable;
        logic [7:0] input_buffer_enable;
    } pgpc_ctrl_s;
    // drive toward the pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } pgpc_pad_s;
endpackage

// ==== design/pgpc_port.sv ====
/*
 pgpc_port: eight-bit general-purpose port with pin control registers,
 routing of pins to a serial channel and to timer inputs and outputs.
 Assumes an APB master on mclk_i, pins asynchronous to mclk_i, and the
 serial and timer peripherals on mclk_i.
*/
// Implementation choices: the placing of the registers and the APB slave port.
// Summary of operation
// R1: each pin has seven separate control bits
// R2: reset clears all control bits to zero
// R3: software input: direction 0, input enable 1
// R4: software output: direction 1, input enable 0
// R5: select one: pins 0-2 carry serial channel
// R6: select one, input: pin 3 feeds capture
// R7: select one, output: pins 4-7 timer flops
// R8: pulls forced off during reset, ordinary types
// R9: boot type pull-up forced on in reset
// R10: disabled input buffer reads constant zero
module pgpc_port #(
    parameter int unsigned NPINS = pgpc_pkg::PINS,
    parameter pgpc_pkg::pgpc_pintype_e PTYPE [8] = '{default:
        pgpc_pkg::PGPC_GENERAL_IO}
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // pads
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pull_up_o,
    output logic      [7:0]  pull_down_o,
    // serial channel one
    input  wire logic        serial_one_clock_out_i,
    output logic             serial_one_clock_in_o,
    output logic             serial_one_receive_o,
    input  wire logic        serial_one_transmit_i,
    // timers
    output logic             timer_one_capture_in_o,
    input  wire logic        timer_one_flop_out_i,
    input  wire logic        timer_four_flop_out_i,
    input  wire logic        timer_five_flop_out_i,
    input  wire logic        timer_six_flop_out_i
);
    // ==========================================================
    // elaboration check
    if (NPINS != 8) begin : g_bad
        $error("pgpc_port serves exactly eight pins");
    end
    // ==========================================================
    // state
    pgpc_pkg::pgpc_ctrl_s ctrl_r;       // all control bits
    logic [7:0]           sync1_r;      // first sync stage
    logic [7:0]           sync2_r;      // second sync stage
    logic [7:0]           gated;        // input after buffer enable
    logic [7:0]           drv_en;       // per-pin drive request
    logic [7:0]           drv_val;      // per-pin drive level
    logic [7:0]           line_rd;      // value read at line offset
    logic                 wr_acc;       // write access phase
    logic                 rd_acc;       // read access phase
    // access phase with zero wait states
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;

    // decode used only by the apb error answer, for reads and writes
    function automatic logic known_ofs(input logic [7:0] a);
        known_ofs = (a == pgpc_pkg::OFS_LINE) || (a == pgpc_pkg::OFS_DIR)
                 || (a == pgpc_pkg::OFS_ALT)  || (a == pgpc_pkg::OFS_OD)
                 || (a == pgpc_pkg::OFS_PU)   || (a == pgpc_pkg::OFS_PD)
                 || (a == pgpc_pkg::OFS_IE)   || (a == pgpc_pkg::OFS_PIN);
    endfunction

    // ==========================================================
    // pin synchroniser: pins are asynchronous
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end
    // buffer off gives constant low, so a floating pad is harmless
    assign gated = sync2_r & ctrl_r.input_buffer_enable; // R10

    // ==========================================================
    // control registers, one field per bit set
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= '0; // R2
        end else if (wr_acc) begin
            unique case (paddr_i) // R1
                pgpc_pkg::OFS_LINE: ctrl_r.port_line_value <= pwdata_i[7:0];
                pgpc_pkg::OFS_DIR:  ctrl_r.port_direction  <= pwdata_i[7:0];
                pgpc_pkg::OFS_ALT:
                    ctrl_r.alt_function_select_one <= pwdata_i[7:0];
                pgpc_pkg::OFS_OD:
                    ctrl_r.open_drain_select <= pwdata_i[7:0];
                pgpc_pkg::OFS_PU:   ctrl_r.pull_up_enable  <= pwdata_i[7:0];
                pgpc_pkg::OFS_PD:   ctrl_r.pull_down_enable <= pwdata_i[7:0];
                pgpc_pkg::OFS_IE:
                    ctrl_r.input_buffer_enable <= pwdata_i[7:0];
                default: ; // pin level and unmapped: no store
            endcase
        end
    end

    // ==========================================================
    // output mux: alternate function replaces the data bit on pins 0, 2 and 4-7
    always_comb begin
        drv_en  = ctrl_r.port_direction; // R4
        drv_val = ctrl_r.port_line_value;
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_SCK])
            drv_val[pgpc_pkg::PIN_SCK] = serial_one_clock_out_i; // R5
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_TXD])
            drv_val[pgpc_pkg::PIN_TXD] = serial_one_transmit_i;  // R5
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_T1])
            drv_val[pgpc_pkg::PIN_T1] = timer_one_flop_out_i;    // R7
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_T4])
            drv_val[pgpc_pkg::PIN_T4] = timer_four_flop_out_i;   // R7
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_T5])
            drv_val[pgpc_pkg::PIN_T5] = timer_five_flop_out_i;   // R7
        if (ctrl_r.alt_function_select_one[pgpc_pkg::PIN_T6])
            drv_val[pgpc_pkg::PIN_T6] = timer_six_flop_out_i;    // R7
    end

    // ==========================================================
    // per-pin pad cells, pull forcing by pad type
    for (genvar i = 0; i < 8; i++) begin : g_pad
        pgpc_pad_cell #(.PTYPE(PTYPE[i])) u_cell (
            .mclk_i      (mclk_i),
            .arst_n_i    (arst_n_i),
            .drive_en_i  (drv_en[i]),
            .drive_val_i (drv_val[i]),
            .od_i        (ctrl_r.open_drain_select[i]),
            .pu_i        (ctrl_r.pull_up_enable[i]),
            .pd_i        (ctrl_r.pull_down_enable[i]),
            .out_o       (pin_o[i]),
            .oe_o        (pin_oe_o[i]),
            .pu_o        (pull_up_o[i]),  // R8 R9
            .pd_o        (pull_down_o[i]) // R8
        );
    end

    // ==========================================================
    // inputs to peripherals, registered; select off gives zero
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_one_clock_in_o  <= 1'b0;
            serial_one_receive_o   <= 1'b0;
            timer_one_capture_in_o <= 1'b0;
        end else begin
            // clock pin is input only with direction 0
            serial_one_clock_in_o <= gated[pgpc_pkg::PIN_SCK]
                && ctrl_r.alt_function_select_one[pgpc_pkg::PIN_SCK]
                && !ctrl_r.port_direction[pgpc_pkg::PIN_SCK]; // R5
            serial_one_receive_o <= gated[pgpc_pkg::PIN_RXD]
                && ctrl_r.alt_function_select_one[pgpc_pkg::PIN_RXD]; // R5
            timer_one_capture_in_o <= gated[pgpc_pkg::PIN_CAP]
                && ctrl_r.alt_function_select_one[pgpc_pkg::PIN_CAP]
                && !ctrl_r.port_direction[pgpc_pkg::PIN_CAP]; // R6
        end
    end

    // ==========================================================
    // line read: inputs show the pin, outputs the data bit
    assign line_rd = (ctrl_r.port_direction & ctrl_r.port_line_value)
                   | (~ctrl_r.port_direction & gated); // R3 R10

    // apb answer, zero wait states, error on unmapped address
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i; // ready in access phase
            pslverr_o <= psel_i && !penable_i && !known_ofs(paddr_i);
            prdata_o  <= 32'h0000_0000;
            if (psel_i && !penable_i && !pwrite_i) begin
                unique case (paddr_i)
                    pgpc_pkg::OFS_LINE: prdata_o[7:0] <= line_rd;
                    pgpc_pkg::OFS_DIR:  prdata_o[7:0] <= ctrl_r.port_direction;
                    pgpc_pkg::OFS_ALT:
                        prdata_o[7:0] <= ctrl_r.alt_function_select_one;
                    pgpc_pkg::OFS_OD:
                        prdata_o[7:0] <= ctrl_r.open_drain_select;
                    pgpc_pkg::OFS_PU:   prdata_o[7:0] <= ctrl_r.pull_up_enable;
                    pgpc_pkg::OFS_PD:
                        prdata_o[7:0] <= ctrl_r.pull_down_enable;
                    pgpc_pkg::OFS_IE:
                        prdata_o[7:0] <= ctrl_r.input_buffer_enable;
                    pgpc_pkg::OFS_PIN:  prdata_o[7:0] <= gated;
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_dir_write;
        wr_acc && paddr_i == pgpc_pkg::OFS_DIR;
    endsequence

    ctrl_clear_a: assert property ( // R2
        $rose(arst_n_i) |-> ctrl_r == '0)
        else $error("control not cleared by reset");
    dir_drive_a: assert property ( // R4
        s_dir_write ##1 (!wr_acc)[*2] |-> pin_oe_o ==
        ($past(ctrl_r.port_direction) & ~($past(ctrl_r.open_drain_select)
        & $past(drv_val))))
        else $error("output enable not following direction");
    ie_gate_a: assert property ( // R10
        ctrl_r.input_buffer_enable == 8'h00 |-> gated == 8'h00)
        else $error("disabled input buffer passes pin");
    txd_route_a: assert property ( // R5
        ctrl_r.alt_function_select_one[2] ##1
        $stable(ctrl_r.alt_function_select_one[2])
        |-> pin_o[2] == $past(serial_one_transmit_i))
        else $error("transmit not routed to pin 2");
    cap_route_a: assert property ( // R6
        !ctrl_r.alt_function_select_one[3] |=> !timer_one_capture_in_o)
        else $error("capture input active without select");
    t6_route_a: assert property ( // R7
        ctrl_r.alt_function_select_one[7] && !wr_acc
        |=> pin_o[7] == $past(timer_six_flop_out_i))
        else $error("timer six not routed to pin 7");
    rxd_route_a: assert property ( // R5
        ctrl_r.alt_function_select_one[1] && !wr_acc
        |=> serial_one_receive_o == $past(gated[1]))
        else $error("receive not routed from pin 1");
    pull_follow_a: assert property ( // R8
        !wr_acc ##1 !wr_acc |-> pull_down_o == $past(ctrl_r.pull_down_enable))
        else $error("pull-down not following enable");
    apb_ready_a: assert property (
        psel_i && !penable_i |=> pready_o)
        else $error("no ready in access phase");
endmodule // pgpc_port

// ==== test/pgpc_board.sv ====
/*
 pgpc_board: board model of the eight port pads.
 Assumes pad drive and pull controls from the port, and an external
 driver that the bench enables per pin.
*/
module pgpc_board (
    // clock
    input  wire logic       mclk_i,
    // port side
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] pull_up_i,
    input  wire logic [7:0] pull_down_i,
    // external driver
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    // resolved pad level
    output logic      [7:0] pad_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // floating pads
    logic [7:0] float_r = 8'h00; // changes every cycle, no stale value
    // toggle so a floating pad is never read as steady
    always @(posedge mclk_i) begin
        float_r <= ~float_r;
    end
    // port drive wins, then board driver, then pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) begin
                pad_level_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_level_o[i] = ext_val_i[i];
            end else if (pull_up_i[i]) begin
                pad_level_o[i] = 1'b1;
            end else if (pull_down_i[i]) begin
                pad_level_o[i] = 1'b0;
            end else begin
                pad_level_o[i] = float_r[i];
            end
        end
    end
endmodule // pgpc_board

// ==== test/test_eight_bit_port_g_pin_control.sv ====
/*
 test_eight_bit_port_g_pin_control: register, pad and routing tests.
 Assumes an APB slave that answers in its own time, board model on pads.
*/
module test_eight_bit_port_g_pin_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic        mclk_i, arst_n_i, psel, penable, pwrite;
    logic [7:0]  paddr, pin_i, pin_o, pin_oe_o, pull_up_o, pull_down_o;
    logic [7:0]  ext_en, ext_val;
    logic [31:0] pwdata, prdata_o, rd;
    logic        pready_o, pslverr_o, err, sck_o, sck_in, rxd, txd;
    logic        cap, t1, t4, t5, t6;
    int          mismatches, compares, cycles;
    // ==========================================================
    // clock and timeout
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // a hang is cut short well above the expected run length
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ==========================================================
    // design and board
    pgpc_port #(.PTYPE('{5: pgpc_pkg::PGPC_INTERRUPT_IN,
        6: pgpc_pkg::PGPC_ANALOG_IN, 7: pgpc_pkg::PGPC_BOOT_IN,
        default: pgpc_pkg::PGPC_GENERAL_IO})) pgpc_port_i (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
        .pull_down_o(pull_down_o), .serial_one_clock_out_i(sck_o),
        .serial_one_clock_in_o(sck_in), .serial_one_receive_o(rxd),
        .serial_one_transmit_i(txd), .timer_one_capture_in_o(cap),
        .timer_one_flop_out_i(t1), .timer_four_flop_out_i(t4),
        .timer_five_flop_out_i(t5), .timer_six_flop_out_i(t6));
    pgpc_board pgpc_board_i (
        .mclk_i(mclk_i), .pad_out_i(pin_o), .pad_oe_i(pin_oe_o),
        .pull_up_i(pull_up_o), .pull_down_i(pull_down_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(pin_i));
    // ==========================================================
    // tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        // answer and read data are taken at the ready edge itself
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    // reset with pulls checked while it is held
    task automatic do_reset();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i);
        check("pull_up", pull_up_o, 8'h80);
        check("pull_down", pull_down_o, 8'h00);
        check("pin_oe", pin_oe_o, 8'h00);
        @(posedge mclk_i);
        arst_n_i <= 1'b1;
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_en, ext_val, sck_o, txd, t1, t4, t5, t6} = '0;
        arst_n_i = 1'b0;
        do_reset();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("reset value", rd, 32'h0);
        end
        for (int i = 1; i < 7; i++) apb(1'b1, 8'(4 * i), 32'(8'h1B * i));
        for (int i = 1; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("control bits", rd, 32'(8'h1B * i));
        end
        settle();
        check("pull_up", pull_up_o, 8'h6C);
        check("pull_down", pull_down_o, 8'h87);
        do_reset();
        for (int i = 1; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("cleared", rd, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", err, 1'b1);
        // software output, then open drain on a high bit
        apb(1'b1, pgpc_pkg::OFS_DIR, 32'hFF);
        apb(1'b1, pgpc_pkg::OFS_LINE, 32'hA5);
        settle();
        check("pin_oe", pin_oe_o, 8'hFF);
        check("pin_o", pin_o, 8'hA5);
        apb(1'b1, pgpc_pkg::OFS_OD, 32'h01);
        settle();
        check("open drain", pin_oe_o, 8'hFE);
        // software input, then buffer disabled
        apb(1'b1, pgpc_pkg::OFS_OD, 32'h00);
        apb(1'b1, pgpc_pkg::OFS_DIR, 32'h00);
        apb(1'b1, pgpc_pkg::OFS_IE, 32'hFF);
        ext_en <= 8'hFF;
        ext_val <= 8'h3C;
        settle();
        apb(1'b0, pgpc_pkg::OFS_LINE, 32'h0);
        check("input", rd, 32'h3C);
        apb(1'b0, pgpc_pkg::OFS_PIN, 32'h0);
        check("pin level", rd, 32'h3C);
        apb(1'b1, pgpc_pkg::OFS_IE, 32'h00);
        settle();
        apb(1'b0, pgpc_pkg::OFS_LINE, 32'h0);
        check("gated input", rd, 32'h0);
        // alternate functions
        apb(1'b1, pgpc_pkg::OFS_ALT, 32'hFF);
        apb(1'b1, pgpc_pkg::OFS_DIR, 32'hF5);
        apb(1'b1, pgpc_pkg::OFS_IE, 32'h0A);
        ext_en <= 8'h0A;
        ext_val <= 8'h0A;
        {sck_o, txd, t1, t4, t5, t6} <= 6'b111010;
        settle();
        check("alt out", pin_o & 8'hF5, 8'h55);
        check("receive", rxd, 1'b1);
        check("capture", cap, 1'b1);
        @(posedge mclk_i);
        {sck_o, txd, t1, t4, t5, t6} <= 6'b000101;
        ext_val <= 8'h00;
        settle();
        check("alt out", pin_o & 8'hF5, 8'hA0);
        check("receive", rxd, 1'b0);
        check("capture", cap, 1'b0);
        apb(1'b1, pgpc_pkg::OFS_DIR, 32'hF4);
        apb(1'b1, pgpc_pkg::OFS_IE, 32'h0B);
        ext_en <= 8'h0B;
        ext_val <= 8'h01;
        settle();
        check("clock in", sck_in, 1'b1);
        report_and_stop();
    end
endmodule // test_eight_bit_port_g_pin_control
